// File: mrsup_core.sv
// reset supervisor: voltage detector and debug reset to core reset, power-up flag
// assumes detector and debug request are asynchronous; no software gate exists
`timescale 1ns/1ps
`default_nettype none
module mrsup_core (
	// clock and reset
	input  wire logic               core_clk,
	input  wire logic               sys_rst,
	// reset sources
	input  wire mrsup_pkg::mrsup_src_t src_in,
	// software access to the power-up flag
	input  wire logic               flag_clear,
	output var  logic               power_up_flag,
	// core reset out
	output var  logic               core_reset
);
	logic               lv_s1_r, lv_s2_r, dbg_s1_r, dbg_s2_r;
	logic               lv_clean;
	logic [mrsup_pkg::CNT_W-1:0] hold_r;
	mrsup_pkg::mrsup_state_t     state_r;
	logic               flag_r, core_reset_r;
	logic               pu_seen_r;
	// helper counters for the checks: low supply samples in a row,
	// and cycles since the filtered supply was last seen low
	logic [mrsup_pkg::CNT_W-1:0] lv_run_r;
	logic [mrsup_pkg::CNT_W-1:0] rec_cnt_r;

	// saturate so a long quiet stretch never wraps into a false short one
	function automatic logic [mrsup_pkg::CNT_W-1:0] sat_inc(
		input logic [mrsup_pkg::CNT_W-1:0] val
	);
		return (val == '1) ? val : val + 1'b1;
	endfunction : sat_inc

	// two-flop synchronisers
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			// power-on implies a low supply, so start from that side
			lv_s1_r  <= mrsup_pkg::SUPPLY_LOW_RST;
			lv_s2_r  <= mrsup_pkg::SUPPLY_LOW_RST;
			dbg_s1_r <= 1'b0;
			dbg_s2_r <= 1'b0;
		end else begin
			lv_s1_r  <= src_in.low_voltage;
			lv_s2_r  <= lv_s1_r;
			dbg_s1_r <= src_in.debug_req;
			dbg_s2_r <= dbg_s1_r;
		end
	end

	mrsup_filter #(.LEN(mrsup_pkg::SPIKE_FILTER_CYC)) u_filter (
		.core_clk  (core_clk),
		.sys_rst   (sys_rst),
		.raw_in    (lv_s2_r),
		.clean_out (lv_clean)
	);

	// no enable term: the low-voltage path cannot be switched off, nor is it
	// gated by idle or power-down, which are not even inputs here
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_r <= mrsup_pkg::MRSUP_LOW;
			hold_r  <= '0;
		end else begin
			case (state_r)
				mrsup_pkg::MRSUP_RUN: begin
					if (lv_clean) begin
						state_r <= mrsup_pkg::MRSUP_LOW;
					end
				end
				mrsup_pkg::MRSUP_LOW: begin
					hold_r <= '0;
					if (!lv_clean) begin
						state_r <= mrsup_pkg::MRSUP_HOLD;
					end
				end
				mrsup_pkg::MRSUP_HOLD: begin
					if (lv_clean) begin
						state_r <= mrsup_pkg::MRSUP_LOW;
					end else if (hold_r >= mrsup_pkg::CNT_W'(mrsup_pkg::RESET_HOLD_CYC - 1)) begin
						state_r <= mrsup_pkg::MRSUP_RUN;
					end else begin
						hold_r <= sat_inc(hold_r);
					end
				end
				default: state_r <= mrsup_pkg::MRSUP_LOW;
			endcase
		end
	end

	// debug reset is combined outside any low-power gating
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			core_reset_r <= 1'b1;
		end else begin
			core_reset_r <= (state_r != mrsup_pkg::MRSUP_RUN) || lv_clean || dbg_s2_r;
		end
	end

	// power-up means the first detector-held reset since power-on reset
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pu_seen_r <= 1'b0;
		end else if (state_r == mrsup_pkg::MRSUP_RUN) begin
			pu_seen_r <= 1'b1;
		end
	end

	// set wins over clear; debug resets never touch it
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			flag_r <= mrsup_pkg::POWER_UP_FLAG_RST;
		end else if (!pu_seen_r && state_r == mrsup_pkg::MRSUP_HOLD) begin
			flag_r <= 1'b1;
		end else if (flag_clear) begin
			flag_r <= 1'b0;
		end
	end

	// check helpers only; nothing in the reset path reads them
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			lv_run_r <= '0;
		end else if (lv_s2_r) begin
			lv_run_r <= sat_inc(lv_run_r);
		end else begin
			lv_run_r <= '0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rec_cnt_r <= '0;
		end else if (lv_clean) begin
			rec_cnt_r <= '0;
		end else begin
			rec_cnt_r <= sat_inc(rec_cnt_r);
		end
	end

	assign core_reset    = core_reset_r;
	assign power_up_flag = flag_r;

	// checks on the reset output, its sources and the power-up flag
	property p_low_resets;
		@(posedge core_clk) disable iff (sys_rst)
		lv_clean |=> core_reset;
	endproperty
	chk_low_resets: assert property (p_low_resets)
		else $error("low supply did not reset core");

	property p_dbg_resets;
		@(posedge core_clk) disable iff (sys_rst)
		dbg_s2_r |=> core_reset;
	endproperty
	chk_dbg_resets: assert property (p_dbg_resets)
		else $error("debug request did not reset core");

	property p_hold_min;
		@(posedge core_clk) disable iff (sys_rst)
		$fell(lv_clean) |-> core_reset [*8];
	endproperty
	chk_hold_min: assert property (p_hold_min)
		else $error("reset released too early");

	property p_flag_sticky;
		@(posedge core_clk) disable iff (sys_rst)
		flag_r && !flag_clear |=> flag_r;
	endproperty
	chk_flag_sticky: assert property (p_flag_sticky)
		else $error("flag cleared without software");

	property p_dbg_no_flag;
		@(posedge core_clk) disable iff (sys_rst)
		!flag_r && pu_seen_r |=> !flag_r;
	endproperty
	chk_dbg_no_flag: assert property (p_dbg_no_flag)
		else $error("flag set by warm reset");

	property p_flag_set;
		@(posedge core_clk) disable iff (sys_rst)
		!pu_seen_r && state_r == mrsup_pkg::MRSUP_HOLD |=> flag_r;
	endproperty
	chk_flag_set: assert property (p_flag_set)
		else $error("flag not set");

	// the filtered level may only rise after a full filter time of low samples
	property p_filter_spike;
		@(posedge core_clk) disable iff (sys_rst)
		$rose(lv_clean) |-> lv_run_r >= mrsup_pkg::SPIKE_FILTER_CYC;
	endproperty
	chk_filter_spike: assert property (p_filter_spike)
		else $error("spike passed");

	property p_release;
		@(posedge core_clk) disable iff (sys_rst)
		$fell(core_reset) |-> !$past(lv_clean) && !$past(dbg_s2_r);
	endproperty
	chk_release: assert property (p_release)
		else $error("released under a source");

	property p_hold_count;
		@(posedge core_clk) disable iff (sys_rst)
		$fell(core_reset) |-> rec_cnt_r >= mrsup_pkg::RESET_HOLD_CYC;
	endproperty
	chk_hold_count: assert property (p_hold_count)
		else $error("release before the hold time");

	property p_run_entry;
		@(posedge core_clk) disable iff (sys_rst)
		state_r == mrsup_pkg::MRSUP_RUN && $past(state_r) != mrsup_pkg::MRSUP_RUN
			|-> rec_cnt_r >= mrsup_pkg::RESET_HOLD_CYC;
	endproperty
	chk_run_entry: assert property (p_run_entry)
		else $error("run entered before the hold time");

	property p_dbg_release;
		@(posedge core_clk) disable iff (sys_rst)
		!dbg_s2_r && !lv_clean && state_r == mrsup_pkg::MRSUP_RUN |=> !core_reset;
	endproperty
	chk_dbg_release: assert property (p_dbg_release)
		else $error("reset held with no source");

	property p_low_state;
		@(posedge core_clk) disable iff (sys_rst)
		lv_clean |=> state_r == mrsup_pkg::MRSUP_LOW;
	endproperty
	chk_low_state: assert property (p_low_state)
		else $error("low supply did not reach low state");

	property p_flag_cause;
		@(posedge core_clk) disable iff (sys_rst)
		$rose(flag_r) |-> $past(state_r) == mrsup_pkg::MRSUP_HOLD && !$past(pu_seen_r);
	endproperty
	chk_flag_cause: assert property (p_flag_cause)
		else $error("flag set outside a power-up");

	property p_clear_works;
		@(posedge core_clk) disable iff (sys_rst)
		flag_clear && !(state_r == mrsup_pkg::MRSUP_HOLD && !pu_seen_r) |=> !flag_r;
	endproperty
	chk_clear_works: assert property (p_clear_works)
		else $error("software clear ignored");

	// main scenarios
	cov_cold: cover property (@(posedge core_clk) disable iff (sys_rst) $rose(flag_r));
	cov_dbg: cover property (@(posedge core_clk) disable iff (sys_rst) $rose(dbg_s2_r));
	cov_brownout: cover property (@(posedge core_clk) disable iff (sys_rst)
		pu_seen_r && $rose(lv_clean));
	cov_spike: cover property (@(posedge core_clk) disable iff (sys_rst)
		$fell(lv_s2_r) && !lv_clean);
	cov_clear: cover property (@(posedge core_clk) disable iff (sys_rst)
		flag_r && flag_clear);
endmodule : mrsup_core
`default_nettype wire

// File: mrsup_pkg.sv
// constants and carriers for the core reset supervisor
// assumes one 250 MHz core clock and a synchronous power-up reset
//
// Operation
// - assert core reset while the voltage detector reports low supply.
// - hold core reset for the hold time after the supply recovers.
// - voltage detector path always enabled, also in idle and power-down.
// - ignore low-supply indications shorter than the spike filter time.
// - a voltage-detector power-up reset latches the power-up flag to one.
// - software can read the power-up flag to tell cold from warm reset.
// - the flag stays set until software clears it explicitly.
// - accept a debug unit reset request and apply it as core reset.
// - debug reset works in idle and power-down modes too.
package mrsup_pkg;
	localparam int CLK_MHZ            = 250;
	// times in nanoseconds; plain defaults, the real figures belong to the silicon
	localparam int SPIKE_FILTER_NS    = 100;
	localparam int RESET_HOLD_NS      = 10000;
	// least times round up
	localparam int SPIKE_FILTER_CYC   = (SPIKE_FILTER_NS * CLK_MHZ + 999) / 1000;
	localparam int RESET_HOLD_CYC     = (RESET_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W              = 16;
	localparam logic POWER_UP_FLAG_RST = 1'b0;
	// power-on counts as a low supply until the detector shows it good
	localparam logic SUPPLY_LOW_RST    = 1'b1;

	typedef struct packed {
		logic low_voltage;
		logic debug_req;
	} mrsup_src_t;

	typedef enum logic [1:0] {
		MRSUP_RUN,
		MRSUP_LOW,
		MRSUP_HOLD
	} mrsup_state_t;
endpackage : mrsup_pkg

// File: mrsup_filter.sv
// spike filter: output follows input only after it held steady for a count
// assumes input already synchronised to core_clk
`timescale 1ns/1ps
`default_nettype none
module mrsup_filter #(
	parameter int LEN = 1
) (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic sys_rst,
	// level in and filtered level out
	input  wire logic raw_in,
	output var  logic clean_out
);
	logic [mrsup_pkg::CNT_W-1:0] cnt_r;
	logic                        clean_r;

	// restart counting whenever input agrees with output; short spikes die
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cnt_r   <= '0;
			clean_r <= mrsup_pkg::SUPPLY_LOW_RST;
		end else if (raw_in == clean_r) begin
			cnt_r <= '0;
		end else if (cnt_r >= mrsup_pkg::CNT_W'(LEN - 1)) begin
			cnt_r   <= '0;
			clean_r <= raw_in;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end
	assign clean_out = clean_r;
endmodule : mrsup_filter
`default_nettype wire

// File: mrsup_partner.sv
// partner model: supply voltage detector and debug unit
// assumes bench commands change just after the rising edge of core_clk
`timescale 1ns/1ps
`default_nettype none
module mrsup_partner (
	// clock
	input  wire logic                  core_clk,
	// commands from the bench
	input  wire logic                  lv_cmd,
	input  wire logic                  dbg_cmd,
	// reset sources to the supervisor
	output var  mrsup_pkg::mrsup_src_t src_out
);
	// the detector has no enable, so a low supply always shows here;
	// a debugger may pull reset to leave a low-power mode
	always_ff @(posedge core_clk) begin
		src_out.low_voltage <= lv_cmd;
		src_out.debug_req   <= dbg_cmd;
	end
endmodule : mrsup_partner
`default_nettype wire

// File: test_mrsup_core.sv
// bench for the core reset supervisor
// assumes the partner model drives both reset sources
`timescale 1ns/1ps
`default_nettype none
module test_mrsup_core;
	logic                  core_clk      = 1'b0;
	logic                  sys_rst       = 1'b1;
	logic                  lv_cmd        = 1'b1;
	logic                  dbg_cmd       = 1'b0;
	logic                  flag_clear    = 1'b0;
	logic                  power_up_flag;
	logic                  core_reset;
	mrsup_pkg::mrsup_src_t src;
	int                    bad_count     = 0;
	int                    total_checks  = 0;
	int                    cycles        = 0;
	always #2 core_clk = ~core_clk;
	mrsup_partner mrsup_partner_inst (.core_clk(core_clk), .lv_cmd(lv_cmd),
		.dbg_cmd(dbg_cmd), .src_out(src));
	mrsup_core mrsup_core_inst (.core_clk(core_clk), .sys_rst(sys_rst), .src_in(src),
		.flag_clear(flag_clear), .power_up_flag(power_up_flag), .core_reset(core_reset));
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc
	task automatic chk(input string nm, input logic seen, input logic exp);
		total_checks++;
		if (seen !== exp) begin
			$display("Error %s expected %b seen %b", nm, exp, seen);
			bad_count++;
		end
	endtask : chk
	task automatic end_sim();
		if (bad_count == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 10000) begin
			bad_count++;
			end_sim();
		end
	end
	// supply low through reset, then recovery and the full hold
	task automatic power_up();
		cyc(40);
		chk("core_reset", core_reset, 1'b1);
		chk("power_up_flag", power_up_flag, 1'b0);
		lv_cmd = 1'b0;
		cyc(60);
		chk("power_up_flag", power_up_flag, 1'b1);
		// one cycle short of the hold measured from the supply change itself
		cyc(mrsup_pkg::RESET_HOLD_CYC - 61);
		chk("core_reset", core_reset, 1'b1);
		cyc(100);
		chk("core_reset", core_reset, 1'b0);
	endtask : power_up
	// a dip shorter than the filter must never reach core reset
	task automatic spike();
		lv_cmd = 1'b1;
		for (int i = 0; i < 40; i++) begin
			if (i == mrsup_pkg::SPIKE_FILTER_CYC - 5) lv_cmd = 1'b0;
			chk("core_reset", core_reset, 1'b0);
			cyc(1);
		end
	endtask : spike
	task automatic debug_rst();
		dbg_cmd = 1'b1;
		cyc(6);
		chk("core_reset", core_reset, 1'b1);
		chk("power_up_flag", power_up_flag, 1'b1);
		dbg_cmd = 1'b0;
		cyc(6);
		chk("core_reset", core_reset, 1'b0);
	endtask : debug_rst
	// software clear, then a brownout that is not a power-up
	task automatic brownout();
		flag_clear = 1'b1;
		cyc(1);
		flag_clear = 1'b0;
		cyc(1);
		chk("power_up_flag", power_up_flag, 1'b0);
		lv_cmd = 1'b1;
		cyc(40);
		chk("core_reset", core_reset, 1'b1);
		lv_cmd = 1'b0;
		cyc(mrsup_pkg::RESET_HOLD_CYC - 1);
		chk("core_reset", core_reset, 1'b1);
		cyc(101);
		chk("core_reset", core_reset, 1'b0);
		chk("power_up_flag", power_up_flag, 1'b0);
	endtask : brownout
	// a second power-on reset in mid-run latches the flag again
	task automatic power_cycle();
		lv_cmd  = 1'b1;
		sys_rst = 1'b1;
		cyc(16);
		sys_rst = 1'b0;
		lv_cmd  = 1'b0;
		chk("power_up_flag", power_up_flag, 1'b0);
		cyc(2);
		chk("core_reset", core_reset, 1'b1);
		cyc(60);
		chk("power_up_flag", power_up_flag, 1'b1);
		chk("core_reset", core_reset, 1'b1);
	endtask : power_cycle
	initial begin
		cyc(16);
		chk("core_reset", core_reset, 1'b1);
		chk("power_up_flag", power_up_flag, 1'b0);
		sys_rst = 1'b0;
		power_up();
		spike();
		debug_rst();
		brownout();
		power_cycle();
		end_sim();
	end
endmodule : test_mrsup_core
`default_nettype wire
